// ### include/nbr_pkg.sv
// Purpose: shared constants for the nine-bit enabled register with 3-state drive
// Assumes: one 40 MHz clock; all control pins are asynchronous to it
// Notes: every count, width and value after reset used by more than one file

package nbr_pkg;

    // ********************************************************************
    // widths and timing
    // ********************************************************************
    localparam int NBR_WIDTH = 9;
    localparam int NBR_SYNC_STAGES = 2;
    localparam int NBR_CLK_PERIOD_PS = 25000;

    // ********************************************************************
    // values after reset
    // ********************************************************************
    localparam logic NBR_RST_STORE = 1'h0;
    // the edge detector starts high so a pin clock held high through reset
    // is never taken for a rising edge
    localparam logic NBR_RST_EDGE = 1'h1;
    localparam logic NBR_RST_DATA = 1'h0;
    localparam logic NBR_RST_GATE_N = 1'h1;
    localparam logic NBR_RST_WIPE_N = 1'h0;
    localparam logic NBR_RST_DRIVE_N = 1'h1;
    localparam logic NBR_RST_OE = 1'h0;

    // ********************************************************************
    // function of the register in one cycle
    // ********************************************************************
    typedef enum logic [2:0]
    {
        NBR_FN_CLEAR = 3'h1,
        NBR_FN_HOLD = 3'h2,
        NBR_FN_LOAD = 3'h4
    } nbr_fn_t;

endpackage

// ### logic/nbr_sync.sv
// Purpose: multi-stage synchroniser for pins entering the REF_CLK domain
// Assumes: the input is a level; each bit is synchronised on its own
// Notes: only the last stage may be read by other logic

`timescale 1ns/1ps

module nbr_sync
    import nbr_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter int STAGES = NBR_SYNC_STAGES,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg [STAGES];

    if (STAGES < 2)
    begin : g_check
        $error("nbr_sync needs at least two stages");
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                stage_reg[i] <= RESET_VALUE;
            end
        end
        else
        begin
            stage_reg[0] <= async_in;
            for (int i = 1; i < STAGES; i++)
            begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign sync_out = stage_reg[STAGES-1];

endmodule

// ### logic/nbr_bit_cell.sv
// Purpose: one storage bit with asynchronous clear and load enable
// Assumes: clr_n already merges the system reset with the clear pin
// Notes: the clear takes only a constant, so it is safe as an async reset

`timescale 1ns/1ps

module nbr_bit_cell
    import nbr_pkg::*;
(
    input wire logic clk,
    input wire logic clr_n,
    input wire logic load_en,
    input wire logic d,
    output logic q
);

    logic q_reg;
    logic q_next;

    always_comb
    begin
        q_next = load_en ? d : q_reg;
    end

    always_ff @(posedge clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            q_reg <= NBR_RST_STORE;
        end
        else
        begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule

// ### logic/nbr_top.sv
// Purpose: nine-bit register fed by a pin clock, with clear, load gate and 3-state drive
// Assumes: EDGE_CLOCK and all control pins are asynchronous to REF_CLK; the pin
//          clock runs well below REF_CLK/4 so every level is seen by the samplers
// Notes: the pad logic resolves DATA_OUT and DATA_OE into the shared bus wire
//
// Notes on behaviour
// - storage is exactly nine bits, one per data input, one per output.
// - each bit takes its own input at the pin clock's rising edge when allowed.
// - one clock and one drive control serve all nine bits together.
// - with output_drive_n low every output is driven with its stored bit.
// - with output_drive_n high all nine outputs float.
// - the drive control never changes the stored contents.
// - wipe_n low forces all bits to zero; driven outputs then read low.
// - data is accepted only while wipe_n is high.
// - load_gate_n low and wipe_n high load the inputs at the rising edge.
// - load_gate_n high keeps the stored value whatever the inputs do.

`timescale 1ns/1ps

module nbr_top
    import nbr_pkg::*;
#(
    parameter int WIDTH = NBR_WIDTH,
    parameter int SYNC_STAGES = NBR_SYNC_STAGES
)
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic EDGE_CLOCK,
    input wire logic [WIDTH-1:0] DATA_IN,
    input wire logic LOAD_GATE_N,
    input wire logic WIPE_N,
    input wire logic OUTPUT_DRIVE_N,
    output logic [WIDTH-1:0] DATA_OUT,
    output logic [WIDTH-1:0] DATA_OE
);

    // ********************************************************************
    // elaboration checks
    // ********************************************************************
    if (WIDTH != NBR_WIDTH)
    begin : g_width_check
        $error("nbr_top storage must be nine bits wide");
    end

    if (SYNC_STAGES < 2)
    begin : g_sync_check
        $error("nbr_top needs at least two synchroniser stages");
    end

    // ********************************************************************
    // reset release
    // ********************************************************************
    logic [1:0] rst_pipe_reg;
    logic rst_n;

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rst_pipe_reg <= 2'h0;
        end
        else
        begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'h1};
        end
    end

    assign rst_n = rst_pipe_reg[1];

    // ********************************************************************
    // pin synchronisers
    // ********************************************************************
    // clock and data share the same depth, so a sampled rising edge lines up
    // with the data level sampled at the same instant
    logic edge_s;
    logic [WIDTH-1:0] data_s;
    logic gate_n_s;
    logic wipe_n_s;
    logic drive_n_s;

    nbr_sync #(.WIDTH(1), .STAGES(SYNC_STAGES), .RESET_VALUE(NBR_RST_EDGE)) u_sync_edge
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .async_in(EDGE_CLOCK),
        .sync_out(edge_s)
    );

    nbr_sync #(.WIDTH(WIDTH), .STAGES(SYNC_STAGES), .RESET_VALUE({WIDTH{NBR_RST_DATA}})) u_sync_data
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .async_in(DATA_IN),
        .sync_out(data_s)
    );

    nbr_sync #(.WIDTH(1), .STAGES(SYNC_STAGES), .RESET_VALUE(NBR_RST_GATE_N)) u_sync_gate
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .async_in(LOAD_GATE_N),
        .sync_out(gate_n_s)
    );

    nbr_sync #(.WIDTH(1), .STAGES(SYNC_STAGES), .RESET_VALUE(NBR_RST_WIPE_N)) u_sync_wipe
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .async_in(WIPE_N),
        .sync_out(wipe_n_s)
    );

    nbr_sync #(.WIDTH(1), .STAGES(SYNC_STAGES), .RESET_VALUE(NBR_RST_DRIVE_N)) u_sync_drive
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .async_in(OUTPUT_DRIVE_N),
        .sync_out(drive_n_s)
    );

    // ********************************************************************
    // rising edge of the pin clock
    // ********************************************************************
    // both stages start as if the pin clock were already high, so a pin left
    // high through reset cannot look like a rising edge and load stray data
    logic edge_prev_reg;
    logic edge_rise;

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_prev_reg <= NBR_RST_EDGE;
        end
        else
        begin
            edge_prev_reg <= edge_s;
        end
    end

    assign edge_rise = edge_s && !edge_prev_reg;

    // ********************************************************************
    // function decode
    // ********************************************************************
    // the synchronised wipe lags the pin, so loads stay blocked for a few
    // cycles after the clear lets go; that hides the async release hazard
    nbr_fn_t fn;
    logic load_en;

    always_comb
    begin
        case ({wipe_n_s, gate_n_s, edge_rise})
            3'h0, 3'h1, 3'h2, 3'h3: fn = NBR_FN_CLEAR;
            3'h4: fn = NBR_FN_HOLD;
            3'h5: fn = NBR_FN_LOAD;
            3'h6, 3'h7: fn = NBR_FN_HOLD;
            default: fn = NBR_FN_HOLD;
        endcase
    end

    assign load_en = (fn == NBR_FN_LOAD);

    // ********************************************************************
    // storage
    // ********************************************************************
    // the clear pin reaches the cells asynchronously; it only ever forces
    // a constant, so the cells need no data path from it
    logic clr_n;
    logic [WIDTH-1:0] store;

    assign clr_n = rst_n && WIPE_N;

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_cell
        nbr_bit_cell u_cell
        (
            .clk(REF_CLK),
            .clr_n(clr_n),
            .load_en(load_en),
            .d(data_s[i]),
            .q(store[i])
        );
    end

    assign DATA_OUT = store;

    // ********************************************************************
    // output drive
    // ********************************************************************
    // one flop set for all pins keeps the nine enables together
    // the clear stays out of this path, so clearing never takes or frees the bus
    logic [WIDTH-1:0] oe_reg;

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_reg <= {WIDTH{NBR_RST_OE}};
        end
        else
        begin
            oe_reg <= {WIDTH{!drive_n_s}};
        end
    end

    assign DATA_OE = oe_reg;

    // ********************************************************************
    // assertions
    // ********************************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking

    default disable iff (!rst_n);

    sequence s_load_request;
        edge_rise && !gate_n_s && wipe_n_s;
    endsequence

    sequence s_clear_still_off;
        WIPE_N && clr_n;
    endsequence

    sequence s_drive_pin_low;
        !OUTPUT_DRIVE_N [*4];
    endsequence

    sequence s_drive_pin_high;
        OUTPUT_DRIVE_N [*4];
    endsequence

    a_oe_on_drive_low: assert property (!drive_n_s |=> (DATA_OE == {WIDTH{1'h1}}))
        else $error("outputs not driven while drive control low");

    a_oe_off_drive_high: assert property (drive_n_s |=> (DATA_OE == {WIDTH{1'h0}}))
        else $error("outputs driven while drive control high");

    a_oe_all_same: assert property ((DATA_OE == {WIDTH{1'h0}}) || (DATA_OE == {WIDTH{1'h1}}))
        else $error("output enables split between bits");

    a_drive_keeps_store: assert property (
        ($changed(drive_n_s) && !load_en && WIPE_N) ##1 s_clear_still_off |-> $stable(store))
        else $error("drive control change altered stored value");

    a_wipe_zeroes: assert property (!WIPE_N |-> (store == {WIDTH{1'h0}}))
        else $error("stored bits not zero while clear low");

    a_wipe_blocks_load: assert property (!wipe_n_s |-> !load_en)
        else $error("load taken while clear active");

    a_load_takes_data: assert property (s_load_request ##1 s_clear_still_off |-> (store == $past(data_s)))
        else $error("load did not capture inputs");

    a_gate_holds: assert property ((gate_n_s && WIPE_N) ##1 s_clear_still_off |-> $stable(store))
        else $error("stored value changed while load gate high");

    a_clear_priority: assert property ((!WIPE_N && edge_rise && !gate_n_s) |-> (store == {WIDTH{1'h0}}))
        else $error("load won over clear");

    a_wipe_lag: assert property ($rose(WIPE_N) |-> !load_en [*2])
        else $error("load accepted right at clear release");

    // the pin-level checks watch the raw drive pin, so a broken synchroniser
    // or a wrong latency shows up instead of being copied into the check
    a_oe_pin_low: assert property (s_drive_pin_low |-> (DATA_OE == {WIDTH{1'h1}}))
        else $error("outputs not driven four cycles after drive pin fell");

    a_oe_pin_high: assert property (s_drive_pin_high |-> (DATA_OE == {WIDTH{1'h0}}))
        else $error("outputs still driven four cycles after drive pin rose");

    a_edge_once: assert property (edge_rise |=> !edge_rise)
        else $error("one pin clock rise seen twice");

    a_idle_holds: assert property ((!load_en && WIPE_N) ##1 s_clear_still_off |-> $stable(store))
        else $error("stored value changed without a load");

    a_load_reaches_out: assert property (s_load_request ##1 s_clear_still_off |-> (DATA_OUT == $past(data_s)))
        else $error("loaded value not on outputs");

    // the clear checks read the raw pin on purpose: the clear acts without a clock
    // and must not wait for the synchronised copy
    a_cleared_bus_low: assert property (
        (!WIPE_N && (DATA_OE == {WIDTH{1'h1}})) |-> (DATA_OUT == {WIDTH{1'h0}}))
        else $error("driven outputs not low while clear low");

    a_fn_one_hot: assert property ($onehot(fn))
        else $error("function decode not one-hot");

    a_hold_keeps_out: assert property ((gate_n_s && WIPE_N) ##1 s_clear_still_off |-> $stable(DATA_OUT))
        else $error("outputs changed while load gate high");

    a_wipe_keeps_on: assert property ((!WIPE_N && !drive_n_s) |=> (DATA_OE == {WIDTH{1'h1}}))
        else $error("clear released the bus");

    a_wipe_keeps_off: assert property ((!WIPE_N && drive_n_s) |=> (DATA_OE == {WIDTH{1'h0}}))
        else $error("clear grabbed the bus");

endmodule

// ### bench/nbr_bus_peer.sv
// Purpose: model of the shared 3-state bus and the other logic that drives it
// Assumes: the bus has no pull-up or pull-down; the peer drives only when told to
// Notes: a released bit shows the inverse of its last level, so a float never passes for a held value

`timescale 1ns/1ps

module nbr_bus_peer
    import nbr_pkg::*;
(
    input wire logic clk,
    input wire logic [NBR_WIDTH-1:0] dev_val,
    input wire logic [NBR_WIDTH-1:0] dev_oe,
    input wire logic peer_en,
    input wire logic [NBR_WIDTH-1:0] peer_val,
    output logic [NBR_WIDTH-1:0] bus_wire
);
    logic [NBR_WIDTH-1:0] last_reg = '0;

    // only a driven level is remembered, so a float keeps showing one steady inverse
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NBR_WIDTH; i++)
        begin
            if (dev_oe[i] || peer_en)
            begin
                last_reg[i] <= bus_wire[i];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NBR_WIDTH; i++)
        begin
            if (dev_oe[i] && peer_en)
                bus_wire[i] = 1'hX;
            else if (dev_oe[i])
                bus_wire[i] = dev_val[i];
            else if (peer_en)
                bus_wire[i] = peer_val[i];
            else
                bus_wire[i] = ~last_reg[i];
        end
    end
endmodule

// ### bench/nine_bit_enabled_register_tristate_test.sv
// Purpose: self-checking bench for the nine-bit register with 3-state drive
// Assumes: pins change at the falling edge of REF_CLK only
// Notes: the pin clock is held two or more periods per level so the samplers see it

`timescale 1ns/1ps

module nine_bit_enabled_register_tristate_test;
    import nbr_pkg::*;

    logic ref_clk = 1'h0;
    logic arst_n = 1'h0;
    logic edge_clock = 1'h0;
    logic load_gate_n = 1'h1;
    logic wipe_n = 1'h1;
    logic output_drive_n = 1'h1;
    logic peer_en = 1'h0;
    logic [NBR_WIDTH-1:0] data_in = '0;
    logic [NBR_WIDTH-1:0] peer_val = '0;
    logic [NBR_WIDTH-1:0] data_out;
    logic [NBR_WIDTH-1:0] data_oe;
    logic [NBR_WIDTH-1:0] bus_wire;
    int err_total = 0;
    int tests_run = 0;

    nbr_top u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .EDGE_CLOCK(edge_clock), .DATA_IN(data_in),
        .LOAD_GATE_N(load_gate_n), .WIPE_N(wipe_n), .OUTPUT_DRIVE_N(output_drive_n),
        .DATA_OUT(data_out), .DATA_OE(data_oe));

    nbr_bus_peer u_peer (.clk(ref_clk), .dev_val(data_out), .dev_oe(data_oe), .peer_en(peer_en),
        .peer_val(peer_val), .bus_wire(bus_wire));

    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ********************************************************************
    // shared tasks
    // ********************************************************************
    task automatic complete_run();
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [NBR_WIDTH-1:0] seen, input logic [NBR_WIDTH-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // one pin clock pulse; data and gate stay put around the rise
    task automatic pulse();
        edge_clock = 1'h1;
        cyc(3);
        edge_clock = 1'h0;
        cyc(3);
    endtask

    task automatic load(input logic [NBR_WIDTH-1:0] v);
        data_in = v;
        cyc(1);
        pulse();
    endtask

    // bounded wait: the enables follow the drive pin a few cycles later
    task automatic set_drive(input logic v);
        logic [NBR_WIDTH-1:0] exp;
        int n;
        exp = v ? 9'h000 : 9'h1FF;
        output_drive_n = v;
        n = 0;
        while (data_oe !== exp && n < 8)
        begin
            cyc(1);
            n++;
        end
        if (data_oe !== exp)
        begin
            check("drive enable wait", data_oe, exp);
            complete_run();
        end
    endtask

    // ********************************************************************
    // scenarios
    // ********************************************************************
    task automatic t_load();
        load_gate_n = 1'h0;
        set_drive(1'h0);
        load(9'h1A5);
        check("load a", data_out, 9'h1A5);
        check("bus a", bus_wire, 9'h1A5);
        load(9'h05A);
        check("load b", data_out, 9'h05A);
        check("enables", data_oe, 9'h1FF);
    endtask

    task automatic t_hold();
        load_gate_n = 1'h1;
        load(9'h1FF);
        check("hold", data_out, 9'h05A);
        load_gate_n = 1'h0;
    endtask

    task automatic t_float();
        set_drive(1'h1);
        check("stored after float", data_out, 9'h05A);
        peer_val = 9'h133;
        peer_en = 1'h1;
        cyc(1);
        check("peer on bus", bus_wire, 9'h133);
        load(9'h0F0);
        check("load floating", data_out, 9'h0F0);
        peer_en = 1'h0;
        set_drive(1'h0);
        check("bus after drive", bus_wire, 9'h0F0);
    endtask

    task automatic t_wipe();
        wipe_n = 1'h0;
        #1;
        check("clear at once", data_out, 9'h000);
        check("clear keeps drive", data_oe, 9'h1FF);
        cyc(1);
        load(9'h1FF);
        check("clear blocks load", data_out, 9'h000);
        check("bus low", bus_wire, 9'h000);
        wipe_n = 1'h1;
        cyc(3);
        load(9'h155);
        check("load after clear", data_out, 9'h155);
    endtask

    initial
    begin
        cyc(2);
        check("reset value", data_out, 9'h000);
        check("reset float", data_oe, 9'h000);
        arst_n = 1'h1;
        cyc(6);
        t_load();
        t_hold();
        t_float();
        t_wipe();
        complete_run();
    end
endmodule
